// ===== hdl/output_divider_sync_ctrl.sv
/*
 * Output PLL post-VCO predivider control and distribution sync control for
 * a channel pair, with its register file on an Avalon-MM slave.
 * Assumes status inputs arrive from other clock domains (three-stage sync)
 * and that the divider fabric honours predivider reset and sync pulses.
 */
// Behaviour
// - predivider applies any ratio code; only legal codes set ratio_ok
// - predivider held in reset while control set
// - direct mode: sync gated by calibration, lock
// - reference mode: sync waits next reference edge
// - auto sync on frequency or phase lock
// - unmasked PLL: hold sync until locked, arm
// - masked PLL: ignore lock, settings govern sync
// - channel B mask releases divider, ignores sync
// - channel A mask releases divider, ignores sync
// - channel mask never enables output drivers
// - unmasked channel gets sync as reset
module output_divider_sync_ctrl #(
    parameter int SYNC_STAGES = 3
) (
    input wire logic ref_clk, // 50 MHz clock
    input wire logic arst_n, // async reset, active low
    input wire logic [out_sync_pkg::ADDR_W-1:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall until answer
    output logic [1:0] avs_response, // 00 ok, 10 slave error
    input wire out_sync_pkg::lock_status_s lock_in, // async status levels
    output logic [3:0] predivider_ratio_out, // applied ratio
    output logic predivider_reset, // hold predivider in reset
    output logic predivider_ratio_ok, // ratio code is legal
    output out_sync_pkg::chan_ctrl_s chan_a, // channel A divider control
    output out_sync_pkg::chan_ctrl_s chan_b // channel B divider control
);

    ////////////////////////////////////////////////////////////////////////
    // registers and bus slave

    logic prediv_rst_bit;
    logic [3:0] ratio;
    logic src_sel;
    out_sync_pkg::auto_sync_e auto_mode;
    logic mask_pll;
    logic mask_b;
    logic mask_a;
    logic sw_sync;
    logic ack;
    logic [31:0] next_rdata;
    logic hit;
    logic armed;
    logic sync_fire;
    out_sync_pkg::sync_state_e state;

    always_comb begin
        hit = 1'b1;
        next_rdata = 32'h0;
        case (avs_address)
            out_sync_pkg::ADDR_PREDIV_CTRL:
                next_rdata[out_sync_pkg::BIT_PREDIV_RST] = prediv_rst_bit;
            out_sync_pkg::ADDR_PREDIV_RATIO: next_rdata[3:0] = ratio;
            out_sync_pkg::ADDR_SYNC_SETTINGS: begin
                next_rdata[out_sync_pkg::BIT_SRC_SEL] = src_sel;
                next_rdata[1:0] = auto_mode;
            end
            out_sync_pkg::ADDR_SYNC_MASKS: begin
                next_rdata[out_sync_pkg::BIT_MASK_PLL] = mask_pll;
                next_rdata[out_sync_pkg::BIT_MASK_B] = mask_b;
                next_rdata[out_sync_pkg::BIT_MASK_A] = mask_a;
            end
            out_sync_pkg::ADDR_SYNC_STATUS: next_rdata[3:0] = {armed, state};
            out_sync_pkg::ADDR_SYNC_CMD: next_rdata = 32'h0;
            default: hit = 1'b0;
        endcase
    end

    // one wait cycle: waitrequest drops the edge after the request, then rises
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
            avs_response <= 2'h0;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if ((avs_read || avs_write) && !ack) begin
                avs_readdata <= avs_read ? next_rdata : 32'h0;
                avs_response <= hit ? 2'h0 : 2'h2;
            end
        end
    end

    // waitrequest itself is the flop, so the bus never sees a gate output
    always_comb ack = !avs_waitrequest;

    logic wr_take;
    always_comb wr_take = avs_write && ack && avs_byteenable[0];

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prediv_rst_bit <= 1'b0;
            ratio <= out_sync_pkg::RATIO_RST;
            src_sel <= 1'b0;
            auto_mode <= out_sync_pkg::AUTO_OFF;
            mask_pll <= 1'b0;
            mask_b <= 1'b0;
            mask_a <= 1'b0;
            sw_sync <= 1'b0;
        end else begin
            sw_sync <= 1'b0;
            if (wr_take) begin
                case (avs_address)
                    out_sync_pkg::ADDR_PREDIV_CTRL:
                        prediv_rst_bit <= avs_writedata[out_sync_pkg::BIT_PREDIV_RST];
                    out_sync_pkg::ADDR_PREDIV_RATIO: ratio <= avs_writedata[3:0];
                    out_sync_pkg::ADDR_SYNC_SETTINGS: begin
                        src_sel <= avs_writedata[out_sync_pkg::BIT_SRC_SEL];
                        auto_mode <= out_sync_pkg::auto_sync_e'(avs_writedata[1:0]);
                    end
                    out_sync_pkg::ADDR_SYNC_MASKS: begin
                        mask_pll <= avs_writedata[out_sync_pkg::BIT_MASK_PLL];
                        mask_b <= avs_writedata[out_sync_pkg::BIT_MASK_B];
                        mask_a <= avs_writedata[out_sync_pkg::BIT_MASK_A];
                    end
                    out_sync_pkg::ADDR_SYNC_CMD:
                        sw_sync <= avs_writedata[out_sync_pkg::BIT_CMD_SYNC];
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status synchronisers: a change counts once stages 2 and 3 agree

    localparam int NSTAT = 5;
    logic [NSTAT-1:0] stat_raw;
    logic [NSTAT-1:0] stat;
    always_comb stat_raw = lock_in;

    genvar gi;
    generate
        for (gi = 0; gi < NSTAT; gi++) begin : g_sync
            logic [SYNC_STAGES-1:0] sh;
            logic filt;
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    sh <= '0;
                    filt <= 1'b0;
                end else begin
                    sh <= {sh[SYNC_STAGES-2:0], stat_raw[gi]};
                    if (sh[SYNC_STAGES-1] == sh[SYNC_STAGES-2]) begin
                        filt <= sh[SYNC_STAGES-1];
                    end
                end
            end
            always_comb stat[gi] = filt;
        end
    endgenerate

    out_sync_pkg::lock_status_s st;
    always_comb st = stat;

    ////////////////////////////////////////////////////////////////////////
    // sync source, arming and automatic triggers

    logic ref_d;
    logic ref_rise;
    logic fl_d;
    logic pl_d;
    logic auto_trig;
    logic pll_ready;
    logic sync_req;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_d <= 1'b0;
            fl_d <= 1'b0;
            pl_d <= 1'b0;
        end else begin
            ref_d <= st.ref_edge;
            fl_d <= st.loop_freq_lock;
            pl_d <= st.loop_phase_lock;
        end
    end

    always_comb begin
        ref_rise = st.ref_edge && !ref_d;
        // reserved code triggers nothing
        case (auto_mode)
            out_sync_pkg::AUTO_FREQ: auto_trig = st.loop_freq_lock && !fl_d;
            out_sync_pkg::AUTO_PHASE: auto_trig = st.loop_phase_lock && !pl_d;
            default: auto_trig = 1'b0;
        endcase
        pll_ready = mask_pll || (st.pll_cal_done && st.pll_locked);
        sync_req = sw_sync || auto_trig;
    end

    // a request seen while not armed is dropped rather than queued
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= out_sync_pkg::ST_HOLD;
            armed <= 1'b0;
            sync_fire <= 1'b0;
        end else begin
            sync_fire <= 1'b0;
            armed <= pll_ready;
            case (state)
                out_sync_pkg::ST_HOLD: begin
                    if (pll_ready) begin
                        state <= out_sync_pkg::ST_ARMED;
                    end
                end
                out_sync_pkg::ST_ARMED: begin
                    if (!pll_ready) begin
                        state <= out_sync_pkg::ST_HOLD;
                    end else if (sync_req && src_sel) begin
                        state <= out_sync_pkg::ST_WAIT_REF;
                    end else if (sync_req) begin
                        sync_fire <= 1'b1;
                    end
                end
                out_sync_pkg::ST_WAIT_REF: begin
                    if (!pll_ready) begin
                        state <= out_sync_pkg::ST_HOLD;
                    end else if (ref_rise) begin
                        sync_fire <= 1'b1;
                        state <= out_sync_pkg::ST_ARMED;
                    end
                end
                default: state <= out_sync_pkg::ST_HOLD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // predivider and channel outputs

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            predivider_ratio_out <= out_sync_pkg::RATIO_RST;
            predivider_reset <= 1'b0;
            predivider_ratio_ok <= 1'b0;
        end else begin
            predivider_ratio_out <= ratio;
            predivider_reset <= prediv_rst_bit;
            predivider_ratio_ok <= ratio >= out_sync_pkg::RATIO_DIV2
                && ratio <= out_sync_pkg::RATIO_MAX
                && ratio != out_sync_pkg::RATIO_GAP;
        end
    end

    // release follows the mask without a sync; drivers are not touched here
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            chan_a <= '0;
            chan_b <= '0;
        end else begin
            chan_a.release_div <= mask_a;
            chan_b.release_div <= mask_b;
            chan_a.sync_rst <= sync_fire && !mask_a;
            chan_b.sync_rst <= sync_fire && !mask_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    AST_RATIO_OK: assert property (@(posedge ref_clk) disable iff (!arst_n)
        predivider_ratio_ok |-> $past(ratio) != out_sync_pkg::RATIO_GAP
            && $past(ratio) >= out_sync_pkg::RATIO_DIV2
            && $past(ratio) <= out_sync_pkg::RATIO_MAX)
        else $error("illegal ratio flagged ok");

    AST_RATIO_COPY: assert property (@(posedge ref_clk) disable iff (!arst_n)
        predivider_ratio_out == $past(ratio))
        else $error("applied ratio does not follow register");

    AST_RATIO_LEGAL: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ($past(ratio) >= out_sync_pkg::RATIO_DIV2 && $past(ratio) <= out_sync_pkg::RATIO_MAX
            && $past(ratio) != out_sync_pkg::RATIO_GAP) |-> predivider_ratio_ok)
        else $error("legal ratio not flagged ok");

    AST_PREDIV_RST: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(prediv_rst_bit) |=> predivider_reset)
        else $error("predivider reset not applied");

    AST_NO_SYNC_UNREADY: assert property (@(posedge ref_clk) disable iff (!arst_n)
        sync_fire |-> $past(pll_ready))
        else $error("sync issued while pll not ready");

    AST_DIRECT: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state == out_sync_pkg::ST_ARMED && pll_ready && sync_req && !src_sel)
            |=> sync_fire ##1 (chan_a.sync_rst || mask_a))
        else $error("direct sync missing");

    AST_REF_WAIT: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state == out_sync_pkg::ST_WAIT_REF && !ref_rise) |=> !sync_fire)
        else $error("sync before reference edge");

    AST_AUTO_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (auto_mode == out_sync_pkg::AUTO_OFF || auto_mode == out_sync_pkg::AUTO_RSVD)
            |-> !auto_trig)
        else $error("auto sync while disabled");

    AST_MASK_PLL: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (mask_pll && state == out_sync_pkg::ST_HOLD) |=> state == out_sync_pkg::ST_ARMED)
        else $error("masked pll did not arm");

    AST_MASK_B: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $past(mask_b, 2) && $past(mask_b) |-> !chan_b.sync_rst && chan_b.release_div)
        else $error("masked channel b synced");

    AST_MASK_A: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $past(mask_a, 2) && $past(mask_a) |-> !chan_a.sync_rst && chan_a.release_div)
        else $error("masked channel a synced");

    AST_UNMASKED: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (sync_fire && !mask_b) |=> chan_b.sync_rst)
        else $error("unmasked channel b missed sync");

    AST_UNMASKED_A: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (sync_fire && !mask_a) |=> chan_a.sync_rst)
        else $error("unmasked channel a missed sync");

    AST_PREDIV_FOLLOW: assert property (@(posedge ref_clk) disable iff (!arst_n)
        predivider_reset == $past(prediv_rst_bit))
        else $error("predivider reset does not follow control");

    AST_REF_FIRE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state == out_sync_pkg::ST_WAIT_REF && pll_ready && ref_rise) |=> sync_fire)
        else $error("reference edge did not fire sync");

    AST_AUTO_FREQ: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state == out_sync_pkg::ST_ARMED && pll_ready && !src_sel
            && auto_mode == out_sync_pkg::AUTO_FREQ && st.loop_freq_lock && !fl_d)
            |=> sync_fire)
        else $error("frequency lock did not fire sync");

    AST_HOLD_UNREADY: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !pll_ready |=> state == out_sync_pkg::ST_HOLD)
        else $error("sync armed while pll not ready");

    AST_RELEASE_ONLY: assert property (@(posedge ref_clk) disable iff (!arst_n)
        chan_a.release_div == $past(mask_a) && chan_b.release_div == $past(mask_b))
        else $error("channel release does not follow its own mask");

endmodule

// ===== shared/out_sync_pkg.sv
/*
 * Package for the output divider sync control block: register offsets,
 * field positions, reset values, codes and carrier structs.
 * Assumes a 50 MHz ref_clk and an Avalon-MM slave with byte addresses.
 */
package out_sync_pkg;

    // byte addresses: each 8-bit register sits alone in a word, so index * 4
    localparam logic [11:0] IDX_PREDIV_CTRL = 12'h433;
    localparam logic [11:0] IDX_PREDIV_RATIO = 12'h434;
    localparam logic [11:0] IDX_SYNC_SETTINGS = 12'h435;
    localparam logic [11:0] IDX_SYNC_MASKS = 12'h436;
    localparam logic [11:0] IDX_SYNC_STATUS = 12'h43F;
    localparam logic [11:0] IDX_SYNC_CMD = 12'h440;
    localparam int ADDR_W = 14;
    localparam logic [13:0] ADDR_PREDIV_CTRL = {IDX_PREDIV_CTRL, 2'b00};
    localparam logic [13:0] ADDR_PREDIV_RATIO = {IDX_PREDIV_RATIO, 2'b00};
    localparam logic [13:0] ADDR_SYNC_SETTINGS = {IDX_SYNC_SETTINGS, 2'b00};
    localparam logic [13:0] ADDR_SYNC_MASKS = {IDX_SYNC_MASKS, 2'b00};
    localparam logic [13:0] ADDR_SYNC_STATUS = {IDX_SYNC_STATUS, 2'b00};
    localparam logic [13:0] ADDR_SYNC_CMD = {IDX_SYNC_CMD, 2'b00};

    // field positions
    localparam int BIT_PREDIV_RST = 1;
    localparam int BIT_SRC_SEL = 2;
    localparam int BIT_MASK_PLL = 2;
    localparam int BIT_MASK_B = 1;
    localparam int BIT_MASK_A = 0;
    localparam int BIT_CMD_SYNC = 0;

    // reset values
    localparam logic [3:0] RATIO_RST = 4'h0;
    localparam logic [7:0] REG_RST = 8'h00;

    // predivider codes
    localparam logic [3:0] RATIO_DIV2 = 4'h2;
    localparam logic [3:0] RATIO_DIV3 = 4'h3;
    localparam logic [3:0] RATIO_GAP = 4'h4;
    localparam logic [3:0] RATIO_MAX = 4'hB;

    typedef enum logic [1:0] {
        AUTO_OFF = 2'h0,
        AUTO_FREQ = 2'h1,
        AUTO_PHASE = 2'h2,
        AUTO_RSVD = 2'h3
    } auto_sync_e;

    typedef enum logic [2:0] {
        ST_HOLD = 3'b001,
        ST_ARMED = 3'b010,
        ST_WAIT_REF = 3'b100
    } sync_state_e;

    // per-channel divider control toward the distribution
    typedef struct packed {
        logic sync_rst;
        logic release_div;
    } chan_ctrl_s;

    // status from the analog loop and the digital loop
    typedef struct packed {
        logic pll_cal_done;
        logic pll_locked;
        logic loop_freq_lock;
        logic loop_phase_lock;
        logic ref_edge;
    } lock_status_s;

endpackage

// ===== verif/output_divider_sync_ctrl_tb.sv
/*
 * Self-checking bench for the output divider sync control block: register
 * bus, predivider ratio and reset, sync gating, sources, auto modes, masks.
 * Assumes the package and design files are compiled first.
 */
module output_divider_sync_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [13:0] avs_address = 14'h0000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    out_sync_pkg::lock_status_s lk = 5'h00;
    logic [3:0] ratio_out;
    logic pre_rst;
    logic ratio_ok;
    out_sync_pkg::chan_ctrl_s chan_a;
    out_sync_pkg::chan_ctrl_s chan_b;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    int pa = 0;
    int pb = 0;
    int ba;
    int bb;
    logic [31:0] q;
    logic [1:0] r;
    logic [7:0] c;

    output_divider_sync_ctrl dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .lock_in(lk), .predivider_ratio_out(ratio_out), .predivider_reset(pre_rst),
        .predivider_ratio_ok(ratio_ok), .chan_a(chan_a), .chan_b(chan_b)
    );

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    // sync pulses last one cycle, so the settled half of the cycle counts them
    always @(negedge ref_clk) begin
        if (chan_a.sync_rst === 1'b1) pa++;
        if (chan_b.sync_rst === 1'b1) pb++;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    function automatic logic legal(input logic [3:0] code);
        return code == 4'h2 || code == 4'h3 || (code >= 4'h5 && code <= 4'hB);
    endfunction

    // one request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [13:0] a, input logic [7:0] d,
                       input logic [3:0] be);
        @(posedge ref_clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        q = avs_readdata;
        r = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic set_lock(input logic [4:0] v);
        @(posedge ref_clk);
        lk <= v;
        tick(10);
    endtask

    task automatic mark();
        ba = pa;
        bb = pb;
    endtask

    task automatic expect_p(input int ea, input int eb);
        tick(20);
        chk(pa - ba, ea, "pulses on channel a");
        chk(pb - bb, eb, "pulses on channel b");
    endtask

    task automatic cmd_expect(input int ea, input int eb);
        mark();
        bus(1'b1, out_sync_pkg::ADDR_SYNC_CMD, 8'h01, 4'hF);
        expect_p(ea, eb);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(45784));
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        bus(1'b0, out_sync_pkg::ADDR_PREDIV_RATIO, 8'h00, 4'hF);
        chk(q[7:0], 8'h00, "ratio reset value");
        chk(r, 2'h0, "read response ok");
        bus(1'b0, out_sync_pkg::ADDR_SYNC_SETTINGS, 8'h00, 4'hF);
        chk(q[7:0], 8'h00, "settings reset value");
        bus(1'b0, out_sync_pkg::ADDR_SYNC_MASKS, 8'h00, 4'hF);
        chk(q[7:0], 8'h00, "masks reset value");
        chk(pre_rst, 1'b0, "predivider reset default");
        bus(1'b0, 14'h0000, 8'h00, 4'hF);
        chk(q, 32'h00000000, "unmapped read data");
        chk(r, 2'h2, "unmapped read response");
        bus(1'b0, out_sync_pkg::ADDR_SYNC_STATUS, 8'h00, 4'hF);
        chk(q[3:0], {1'b0, out_sync_pkg::ST_HOLD}, "held before lock");
        // every code, then random bytes whose reserved bits must not matter
        // the VCO is taken to stay under the divide-by-two limit throughout
        for (int i = 0; i < 24; i++) begin
            c = (i < 16) ? 8'(i) : 8'($urandom);
            bus(1'b1, out_sync_pkg::ADDR_PREDIV_RATIO, c, 4'hF);
            tick(2);
            chk(ratio_out, c[3:0], "applied ratio");
            chk(ratio_ok, legal(c[3:0]), "ratio legality");
            bus(1'b0, out_sync_pkg::ADDR_PREDIV_RATIO, 8'h00, 4'hF);
            chk(q[3:0], c[3:0], "ratio readback");
        end
        bus(1'b1, out_sync_pkg::ADDR_PREDIV_RATIO, 8'h05, 4'hE);
        tick(2);
        chk(ratio_out, c[3:0], "lane 0 disabled write ignored");
        bus(1'b1, out_sync_pkg::ADDR_PREDIV_CTRL, 8'h02, 4'hF);
        tick(2);
        chk(pre_rst, 1'b1, "predivider held in reset");
        bus(1'b1, out_sync_pkg::ADDR_PREDIV_CTRL, 8'h00, 4'hF);
        tick(2);
        chk(pre_rst, 1'b0, "predivider released");
        // loop not yet calibrated and locked: sync held off
        cmd_expect(0, 0);
        set_lock(5'h18);
        bus(1'b0, out_sync_pkg::ADDR_SYNC_STATUS, 8'h00, 4'hF);
        chk(q[3:0], {1'b1, out_sync_pkg::ST_ARMED}, "armed after lock");
        cmd_expect(1, 1);
        bus(1'b1, out_sync_pkg::ADDR_SYNC_MASKS, 8'h01, 4'hF);
        tick(2);
        chk(chan_a.release_div, 1'b1, "channel a released");
        chk(chan_b.release_div, 1'b0, "channel b untouched");
        cmd_expect(0, 1);
        bus(1'b1, out_sync_pkg::ADDR_SYNC_MASKS, 8'h02, 4'hF);
        tick(2);
        chk({chan_a.release_div, chan_b.release_div}, 2'h1, "channel b released");
        cmd_expect(1, 0);
        bus(1'b1, out_sync_pkg::ADDR_SYNC_MASKS, 8'h00, 4'hF);
        set_lock(5'h00);
        cmd_expect(0, 0);
        bus(1'b1, out_sync_pkg::ADDR_SYNC_MASKS, 8'h04, 4'hF);
        tick(10);
        cmd_expect(1, 1);
        // reference mode waits for the next reference edge
        bus(1'b1, out_sync_pkg::ADDR_SYNC_SETTINGS, 8'h04, 4'hF);
        cmd_expect(0, 0);
        bus(1'b0, out_sync_pkg::ADDR_SYNC_STATUS, 8'h00, 4'hF);
        chk(q[3:0], {1'b1, out_sync_pkg::ST_WAIT_REF}, "waiting for reference");
        mark();
        @(posedge ref_clk);
        lk <= 5'h01;
        repeat (3) @(posedge ref_clk);
        lk <= 5'h00;
        expect_p(1, 1);
        // each auto code against a frequency lock rise then a phase lock rise
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, out_sync_pkg::ADDR_SYNC_SETTINGS, 8'(m), 4'hF);
            set_lock(5'h00);
            mark();
            set_lock(5'h04);
            expect_p(m == 1, m == 1);
            mark();
            set_lock(5'h06);
            expect_p(m == 2, m == 2);
        end
        report_and_stop();
    end
endmodule
